// File: hw/ssd_pkg.sv
// Package for the scan driven seven segment display sequencer.
// Assumes a single 10 MHz clock; one scan cycle is one enabled clock.
package ssd_pkg;

   // ****************************************************************
   // Sizes and timing
   // ****************************************************************
   localparam int unsigned SSD_CLK_HZ        = 10_000_000;
   localparam int unsigned SSD_ROUND_CYCLES  = 12;
   localparam int unsigned SSD_STEP_CYCLES   = 3;
   localparam int unsigned SSD_LATCHES       = 4;
   localparam int unsigned SSD_DIGIT_W       = 4;
   localparam int unsigned SSD_OUT_W         = 16;
   localparam logic [3:0]  SSD_LAST_CYCLE    = 4'hB;
   localparam logic [1:0]  SSD_LAST_PHASE    = 2'h2;

   // ****************************************************************
   // Control constant fields
   // ****************************************************************
   localparam int unsigned SSD_CTRL_W        = 16;
   localparam logic [15:0] SSD_CTRL_MAX      = 16'h0007;
   localparam int unsigned SSD_CTRL_WIDE_BIT = 2;
   localparam int unsigned SSD_CTRL_DINV_BIT = 1;
   localparam int unsigned SSD_CTRL_LINV_BIT = 0;

   // ****************************************************************
   // Output word field positions
   // ****************************************************************
   localparam int unsigned SSD_N_DATA_LSB    = 0;
   localparam int unsigned SSD_N_LATCH_LSB   = 4;
   localparam int unsigned SSD_N_ROUND_BIT   = 8;
   localparam int unsigned SSD_W_LEFT_LSB    = 0;
   localparam int unsigned SSD_W_RIGHT_LSB   = 4;
   localparam int unsigned SSD_W_LATCH_LSB   = 8;
   localparam int unsigned SSD_W_ROUND_BIT   = 12;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0]  SSD_CYCLE_RST     = 4'h0;
   localparam logic [15:0] SSD_WORD_RST      = 16'h0000;

endpackage : ssd_pkg

// File: hw/ssd_step_counter.sv
// Round position counter for the display sequencer.
// Assumes restart and advance come from logic on the same clock.
`timescale 1ns/1ps
module ssd_step_counter
   import ssd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       restart,
   output logic [3:0]      cycle,
   output logic            last
);

   typedef struct packed {
      logic [3:0] cycle;
   } ssd_cnt_type;

   ssd_cnt_type state_q;
   ssd_cnt_type state_d;

   // Wraps after the last cycle so rounds run back to back
   always_comb
   begin
      state_d = state_q;
      // Restart cycle itself is cycle zero, so the count goes on at one;
      // loading zero here would stretch the first round to 13 cycles
      if (restart)
         state_d.cycle = SSD_CYCLE_RST + 4'h1;
      else if (state_q.cycle == SSD_LAST_CYCLE)
         state_d.cycle = SSD_CYCLE_RST;
      else
         state_d.cycle = state_q.cycle + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state_q <= '{cycle: SSD_CYCLE_RST};
      else if (ce)
         state_q <= state_d;
   end

   assign cycle = state_q.cycle;
   assign last  = (state_q.cycle == SSD_LAST_CYCLE);

endmodule : ssd_step_counter

// File: hw/ssd_scan_driver.sv
// Seven segment scan driver: steps four or eight BCD digits through
// shared data lines and four latch strobes, one round per 12 cycles.
// Assumes run, ctrl and source words come from logic on this clock.
`timescale 1ns/1ps
module ssd_scan_driver
   import ssd_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  run,
   input  wire logic [SSD_CTRL_W-1:0] ctrl,
   input  wire logic [15:0]           src_lo,
   input  wire logic [15:0]           src_hi,
   output logic [SSD_OUT_W-1:0]       out_word,
   output logic                       fault_indicator,
   output logic                       ctrl_bad
);
   import ssd_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic        run;
      logic [15:0] lo;
      logic [15:0] hi;
      logic [15:0] out;
      logic        bad;
   } ssd_state_type;

   ssd_state_type state_q;
   ssd_state_type state_d;

   logic       restart;
   logic [3:0] cycle;
   logic       last;
   logic [1:0] pos;
   logic [1:0] phase;
   logic       strobe;
   logic       wide;
   logic       dinv;
   logic       linv;
   logic [3:0] code_l;
   logic [3:0] code_r;
   logic [3:0] strobes;

   // Restart on rising run; resumed runs never continue mid-round
   assign restart = run & ~state_q.run;

   ssd_step_counter u_cnt (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .restart (restart),
      .cycle   (cycle),
      .last    (last)
   );

   // ****************************************************************
   // Decode of round position and control
   // ****************************************************************
   // Three cycles per strobe; the restart cycle decodes as cycle 0 whatever the counter holds
   assign pos    = 2'((restart ? 4'h0 : cycle) / 4'(SSD_STEP_CYCLES));
   assign phase  = 2'((restart ? 4'h0 : cycle) % 4'(SSD_STEP_CYCLES));
   assign strobe = (phase == 2'h1);
   assign wide   = ctrl[SSD_CTRL_WIDE_BIT];
   assign dinv   = ctrl[SSD_CTRL_DINV_BIT];
   assign linv   = ctrl[SSD_CTRL_LINV_BIT];

   // Digit lsb first; right block from second word in wide mode.
   // The restart cycle reads the source words directly, because the
   // snapshot only lands at that edge; data then stays put round strobe 0
   always_comb
   begin
      if (restart)
      begin
         code_l = src_lo[SSD_DIGIT_W-1:0];
         code_r = src_hi[SSD_DIGIT_W-1:0];
      end
      else
      begin
         code_l = state_q.lo[pos*SSD_DIGIT_W +: SSD_DIGIT_W];
         code_r = state_q.hi[pos*SSD_DIGIT_W +: SSD_DIGIT_W];
      end
      strobes = 4'h0;
      strobes[pos] = strobe;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   // Output word is registered so pins never glitch between phases
   always_comb
   begin
      state_d     = state_q;
      state_d.run = run;
      state_d.bad = (ctrl > SSD_CTRL_MAX);
      // Snapshot at each round start, source edits wait a round
      if (restart || (run && last))
      begin
         state_d.lo = src_lo;
         state_d.hi = src_hi;
      end
      if (!run)
         state_d.out = SSD_WORD_RST;
      else
      begin
         state_d.out = SSD_WORD_RST;
         if (wide)
         begin
            // Both blocks share one set of strobes
            state_d.out[SSD_W_LEFT_LSB +: 4]  =
               code_l ^ {4{dinv}};
            state_d.out[SSD_W_RIGHT_LSB +: 4] =
               code_r ^ {4{dinv}};
            state_d.out[SSD_W_LATCH_LSB +: 4] =
               strobes ^ {4{linv}};
            state_d.out[SSD_W_ROUND_BIT] =
               ~restart & last;
         end
         else
         begin
            state_d.out[SSD_N_DATA_LSB +: 4]  =
               code_l ^ {4{dinv}};
            state_d.out[SSD_N_LATCH_LSB +: 4] =
               strobes ^ {4{linv}};
            state_d.out[SSD_N_ROUND_BIT] =
               ~restart & last;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
         state_q <= '0;
      else if (ce)
         state_q <= state_d;
   end

   // Every digit position is cycled whatever the display fitted
   assign out_word        = state_q.out;
   assign fault_indicator = 1'b0;
   assign ctrl_bad        = state_q.bad;

endmodule : ssd_scan_driver

// File: tb/ssd_scan_asserts.sv
// Checker for the scan driver, bound to its ports from the bench top.
// Assumes ce held high and ctrl changed only while run is low.
`timescale 1ns/1ps
module ssd_scan_asserts
   import ssd_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  ce,
   input wire logic                  run,
   input wire logic [SSD_CTRL_W-1:0] ctrl,
   input wire logic [SSD_OUT_W-1:0]  out_word,
   input wire logic                  fault_indicator,
   input wire logic                  ctrl_bad
);
   // Latch polarity undone so one form serves all eight modes
   wire [3:0] stb = (ctrl[2] ? out_word[11:8] : out_word[7:4]) ^ {4{ctrl[0]}};
   wire       flg = ctrl[2] ? out_word[12] : out_word[8];
   wire [7:0] dat = ctrl[2] ? out_word[7:0] : {4'h0, out_word[3:0]};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_fault_low: assert property (fault_indicator == 1'b0)
      else $error("fault indicator raised");
   a_idle_zero: assert property (ce && !run |=> out_word == 16'h0000)
      else $error("output not zero while stopped");
   a_flag_single: assert property (flg |=> !flg)
      else $error("round flag longer than one cycle");
   a_round_period: assert property ((flg && run) ##1 run[*8] ##1 run[*3] |=> flg)
      else $error("round flag period not 12");
   a_strobe_onehot: assert property (run |=> $onehot0(stb))
      else $error("more than one strobe active");
   a_flag_after_last: assert property (flg |-> $past(stb[3]))
      else $error("flag without last strobe before it");
   a_strobe_order: assert property ((stb[0] && run && $past(run)) ##1 run[*2] |=> stb[1])
      else $error("strobe 1 not three cycles after strobe 0");
   a_data_held: assert property ((stb != 4'h0 && run && $past(run)) |-> $stable(dat) ##1 $stable(dat))
      else $error("data moved around a strobe");
   a_ctrl_range: assert property (!$past(rst) |-> ctrl_bad == $past(ctrl > SSD_CTRL_MAX))
      else $error("range status wrong");
   c_narrow: cover property (flg && !ctrl[2]);
   c_wide: cover property (flg && ctrl[2]);
   c_bad: cover property (ctrl_bad);
endmodule : ssd_scan_asserts

// File: tb/ssd_disp_model.sv
// Latched display: keeps each digit loaded by its strobe until that strobe comes again.
// Assumes out_word and mode come straight from the driver.
`timescale 1ns/1ps
module ssd_disp_model
(
   input  wire logic        clk,
   input  wire logic [15:0] ow,
   input  wire logic [2:0]  md,
   output logic      [15:0] shown_lo,
   output logic      [15:0] shown_hi
);
   // Strobe-enabled register per digit, loaded on the clock edge; polarity undone as the mode says
   always @(posedge clk)
   begin
      for (int k = 0; k < 4; k++)
      begin
         if (((md[2] ? ow[8+k] : ow[4+k]) ^ md[0]) === 1'b1)
         begin
            shown_lo[4*k+:4] <= ow[3:0] ^ {4{md[1]}};
            shown_hi[4*k+:4] <= ow[7:4] ^ {4{md[1]}};
         end
      end
   end
endmodule : ssd_disp_model

// File: tb/ssd_scan_driver_tb_top.sv
// Bench top: sweeps all modes, source resampling and restarts.
// Assumes the checker and display model compile ahead of it.
`timescale 1ns/1ps
module ssd_scan_driver_tb_top;
   import ssd_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        run = 1'b0;
   logic [15:0] ctrl = 16'h0000;
   logic [15:0] src_lo = 16'h0000;
   logic [15:0] src_hi = 16'h0000;
   logic [15:0] out_word, shown_lo, shown_hi;
   logic        fault_indicator, ctrl_bad;
   int          bad_count = 0;
   int          comparisons = 0;
   int          n;
   always #50 clk = ~clk;
   ssd_scan_driver dut_u (.clk, .rst, .ce, .run, .ctrl, .src_lo, .src_hi,
      .out_word, .fault_indicator, .ctrl_bad);
   ssd_disp_model disp_u (.clk, .ow(out_word), .md(ctrl[2:0]), .shown_lo,
      .shown_hi);
   task chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, s, e);
      end
   endtask : chk
   task close_out;
      $display("compares %0d errors %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // Inputs always move 1 ns after the edge
   task step;
      @(posedge clk);
      #1;
   endtask : step
   // Bounded wait; n ends as edges until the round flag shows
   task wait_flag;
      n = 0;
      do begin step(); n++; end
      while (out_word[ctrl[2] ? 12 : 8] !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         bad_count++;
         close_out();
      end
   endtask : wait_flag
   // Bench never reaches into the sequencing state
   initial
   begin
      repeat (10) step();
      rst = 1'b0;
      for (int m = 0; m < 8; m++)
      begin
         ctrl = 16'(m);
         src_lo = 16'h4321 + 16'(m);
         src_hi = 16'h9870 + 16'(m);
         run = 1'b1;
         wait_flag();
         chk(16'(n), 16'h000C);
         chk(shown_lo, src_lo);
         if (m > 3) chk(shown_hi, src_hi);
         src_lo = 16'h1234;
         wait_flag();
         chk(16'(n), 16'h000C);
         chk(shown_lo, 16'h4321 + 16'(m));
         wait_flag();
         chk(shown_lo, 16'h1234);
         repeat (5) step();
         run = 1'b0;
         step();
         run = 1'b1;
         wait_flag();
         chk(16'(n), 16'h000C);
         run = 1'b0;
         step();
         chk(out_word, 16'h0000);
         chk(16'(fault_indicator), 16'h0000);
      end
      ctrl = 16'h0008;
      repeat (2) step();
      chk(16'(ctrl_bad), 16'h0001);
      close_out();
   end
endmodule : ssd_scan_driver_tb_top
bind ssd_scan_driver ssd_scan_asserts chk_u (.clk, .rst, .ce, .run, .ctrl,
   .out_word, .fault_indicator, .ctrl_bad);
